/* File: hdl/dlcm_pkg.sv */
// shared constants and types of the delay-locked clock manager
package dlcm_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned STOP_TIME_US  = 100;
    localparam int unsigned STOP_CYCLES   = STOP_TIME_US * 1000000 / CLK_PERIOD_PS;
    localparam int unsigned LOCK_LOSS_SRC = 4;
    localparam int unsigned LOCK_COUNT    = 4;

    // ****************************************
    // register map, byte offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_ST = 8'h08;
    localparam logic [7:0] OFS_IRQ_CL = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    localparam logic [7:0] OFS_PERIOD = 8'h14;

    // ctrl fields
    localparam int unsigned CTRL_DCC  = 0;
    localparam int unsigned CTRL_WAIT = 1;
    localparam int unsigned CTRL_RST  = 2;
    localparam int unsigned CTRL_SEL  = 4;
    localparam int unsigned SEL_W     = 3;
    localparam logic [7:0] CTRL_RESET = 8'h11;

    // status fields
    localparam int unsigned STAT_LOCK = 0;
    localparam int unsigned STAT_ST   = 1;
    localparam int unsigned STAT_TAP  = 8;

    // interrupt events
    localparam int unsigned IRQ_N    = 4;
    localparam int unsigned IRQ_LOCK = 0;
    localparam int unsigned IRQ_LOSS = 1;
    localparam int unsigned IRQ_STOP = 2;
    localparam int unsigned IRQ_LONG = 3;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEEK = 3'b010,
        ST_LOCK = 3'b100
    } dlcm_state_type;

    typedef struct packed {
        logic        rise;
        logic        stall;
        logic        overlong;
        logic [15:0] period;
    } dlcm_edge_type;

    // divide ratio times two: 1.5 2 2.5 3 4 5 8 16
    function automatic logic [5:0] dlcm_ratio2(input logic [2:0] sel);
        logic [5:0] r;
        r = 6'h02;
        case (sel)
            3'h0: r = 6'h03;
            3'h1: r = 6'h04;
            3'h2: r = 6'h05;
            3'h3: r = 6'h06;
            3'h4: r = 6'h08;
            3'h5: r = 6'h0A;
            3'h6: r = 6'h10;
            default: r = 6'h20;
        endcase
        return r;
    endfunction

endpackage

/* File: hdl/dlcm_period_meter.sv */
// edge detector and period counter for one sampled clock pin
`timescale 1ns/1ps
`default_nettype none
module dlcm_period_meter #(
    parameter int unsigned STOP = dlcm_pkg::STOP_CYCLES
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             clear_i,
    // sampled pin
    input  wire logic             level_i,
    // edge, stall and period
    output var dlcm_pkg::dlcm_edge_type edge_o
);
    initial
    begin
        if (STOP < 4 || STOP > 32'h0000_FFFF)
            $error("dlcm_period_meter: STOP out of range");
    end

    logic        prev_r;
    logic [15:0] cnt_r;
    logic [15:0] per_r;
    logic        rise;

    assign rise = level_i & ~prev_r;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            prev_r <= 1'b0;
        else
            prev_r <= level_i;
    end

    // counter saturates so a long stop cannot wrap into a fake period
    always_ff @(posedge clk_i)
    begin
        if (reset_i || clear_i)
        begin
            cnt_r <= 16'h0000;
            per_r <= 16'h0000;
        end
        else if (rise)
        begin
            cnt_r <= 16'h0001;
            per_r <= cnt_r;
        end
        else if (cnt_r != 16'hFFFF)
            cnt_r <= cnt_r + 16'h0001;
    end

    assign edge_o.rise     = rise;
    assign edge_o.stall    = (per_r != 16'h0000) && ({1'b0, cnt_r} > {per_r, 1'b0});
    assign edge_o.overlong = (per_r != 16'h0000) && (32'(cnt_r) >= STOP);
    assign edge_o.period   = per_r;
endmodule
`default_nettype wire

/* File: hdl/dlcm_delay_line.sv */
// tapped delay line; delay is tap plus two clock cycles
`timescale 1ns/1ps
`default_nettype none
module dlcm_delay_line #(
    parameter int unsigned DEPTH = 64,
    parameter int unsigned TW    = $clog2(DEPTH)
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    input  wire logic          clear_i,
    // data and tap
    input  wire logic          d_i,
    input  wire logic [TW-1:0] tap_i,
    output logic               q_o
);
    initial
    begin
        if (DEPTH < 4 || DEPTH != (1 << TW))
            $error("dlcm_delay_line: DEPTH must be a power of two");
    end

    logic [DEPTH-1:0] line_r;

    // clearing flushes old edges, so a restart starts from an empty line
    always_ff @(posedge clk_i)
    begin
        if (reset_i || clear_i)
        begin
            line_r <= '0;
            q_o    <= 1'b0;
        end
        else
        begin
            line_r <= {line_r[DEPTH-2:0], d_i};
            q_o    <= line_r[tap_i];
        end
    end
endmodule
`default_nettype wire

/* File: hdl/dlcm_top.sv */
// delay-locked clock manager: deskew, doubling, division, lock and registers
// Function
// RL1 - lock drops within four source cycles
// RL2 - loop reset active high, driven or tied
// RL3 - reset returns all taps to zero
// RL4 - user resets on frequency or config change
// RL5 - double clock; 1x 25/75 before lock
// RL6 - divided clock by eight ratios, 50/50
// RL7 - feedback only from aligned or double
// RL8 - startup hold defaults off, waits lock
// RL9 - source drift and jitter within limits
// RL10 - period jump needs a manual reset
// RL11 - short low stop keeps lock high
// RL12 - unsure stop needs a manual reset
// RL13 - outputs flush then refill after stop
// RL14 - phase shift passes, control untouched
// RL15 - users wait for lock before use
// RL16 - cascade: reset second loop, two max
// RL17 - aligned clock 50/50 unless correction off
// RL18 - configuration completion held until lock
// RL19 - lock only once feedback is aligned
`timescale 1ns/1ps
`default_nettype none
module dlcm_top #(
    parameter int unsigned DEPTH       = 64,
    parameter int unsigned STOP_CYCLES = dlcm_pkg::STOP_CYCLES
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // clock pins and loop control
    input  wire logic        source_clock_in_i,
    input  wire logic        feedback_clock_in_i,
    input  wire logic        loop_reset_i,
    input  wire logic        config_done_i,
    // generated clocks and status
    output logic             aligned_clock_out_o,
    output logic             double_clock_out_o,
    output logic             divided_clock_out_o,
    output logic             locked_o,
    output logic             startup_release_o,
    output logic             irq_o,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o
);
    localparam int unsigned TW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 4 || DEPTH > 256)
            $error("dlcm_top: DEPTH out of range");
    end

    // ****************************************
    // declarations
    // ****************************************
    dlcm_pkg::dlcm_edge_type  src_e;
    dlcm_pkg::dlcm_edge_type  fb_e;
    dlcm_pkg::dlcm_state_type state_r;
    logic [7:0]               ctrl_r;
    logic [TW-1:0]            tap_r;
    logic [2:0]               align_r;
    logic                     loop_rst;
    logic                     dly;
    logic                     dly_q_r;
    logic                     drise;
    logic [15:0]              ph_r;
    logic [15:0]              per;
    logic [15:0]              quarter;
    logic                     run;
    logic [21:0]              div_half;
    logic [21:0]              div_cnt_r;
    logic                     aligned_fb;
    logic                     lock;
    logic [3:0]               irq_st_r;
    logic [3:0]               irq_en_r;
    logic [3:0]               irq_ev;
    logic                     stall_q_r;
    logic                     long_q_r;
    logic                     acc;

    // ****************************************
    // edge meters and delay line
    // ****************************************
    // a user loop reset is a pin; software adds its own reset bit
    assign loop_rst = loop_reset_i | ctrl_r[dlcm_pkg::CTRL_RST]; // RL2

    dlcm_period_meter #(.STOP(STOP_CYCLES)) u_src (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .clear_i (loop_rst),
        .level_i (source_clock_in_i),
        .edge_o  (src_e)
    );

    // feedback is trusted to be the aligned or double clock looped back
    dlcm_period_meter #(.STOP(STOP_CYCLES)) u_fb ( // RL7
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .clear_i (loop_rst),
        .level_i (feedback_clock_in_i),
        .edge_o  (fb_e)
    );

    dlcm_delay_line #(.DEPTH(DEPTH), .TW(TW)) u_line (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .clear_i (loop_rst),
        .d_i     (source_clock_in_i),
        .tap_i   (tap_r),
        .q_o     (dly)
    );

    // ****************************************
    // lock control
    // ****************************************
    assign aligned_fb = fb_e.rise & src_e.rise;
    assign lock       = (state_r == dlcm_pkg::ST_LOCK);
    assign locked_o   = state_r[2];

    always_ff @(posedge clk_i)
    begin
        if (reset_i || loop_rst)
            state_r <= dlcm_pkg::ST_IDLE; // RL1
        else
        begin
            case (state_r)
                dlcm_pkg::ST_IDLE:
                    state_r <= dlcm_pkg::ST_SEEK;
                dlcm_pkg::ST_SEEK:
                    if (aligned_fb && 32'(align_r) == dlcm_pkg::LOCK_COUNT - 1)
                        state_r <= dlcm_pkg::ST_LOCK; // RL19
                // a stop, jump or shift never unlocks; only a reset does
                dlcm_pkg::ST_LOCK:
                    state_r <= dlcm_pkg::ST_LOCK; // RL11 RL10 RL12
                default:
                    state_r <= dlcm_pkg::ST_IDLE;
            endcase
        end
    end

    // taps only move while seeking, so a phase shift just flows through
    always_ff @(posedge clk_i)
    begin
        if (reset_i || loop_rst)
        begin
            tap_r   <= '0; // RL3
            align_r <= 3'h0;
        end
        else if (state_r == dlcm_pkg::ST_SEEK && fb_e.rise)
        begin
            if (aligned_fb)
                align_r <= align_r + 3'h1; // RL19
            else
            begin
                align_r <= 3'h0;
                tap_r   <= tap_r + 1'b1; // RL14
            end
        end
    end

    // ****************************************
    // output clock shaping
    // ****************************************
    assign drise    = dly & ~dly_q_r;
    assign per      = src_e.period;
    assign quarter  = {2'b00, per[15:2]};
    assign run      = (ph_r < per);
    assign div_half = (22'(per) * 22'(dlcm_pkg::dlcm_ratio2(
                          ctrl_r[dlcm_pkg::CTRL_SEL +: dlcm_pkg::SEL_W]))) >> 2;

    // phase counter restarts on each delayed edge and dies out after a stop
    always_ff @(posedge clk_i)
    begin
        if (reset_i || loop_rst)
        begin
            dly_q_r <= 1'b0;
            ph_r    <= 16'hFFFF;
        end
        else
        begin
            dly_q_r <= dly;
            if (drise)
                ph_r <= 16'h0000;
            else if (ph_r != 16'hFFFF)
                ph_r <= ph_r + 16'h0001; // RL13
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i || loop_rst)
            aligned_clock_out_o <= 1'b0;
        else if (ctrl_r[dlcm_pkg::CTRL_DCC])
            aligned_clock_out_o <= run && (ph_r < {1'b0, per[15:1]}); // RL17
        else
            aligned_clock_out_o <= dly;
    end

    // before lock: one high quarter per source period; after: two
    always_ff @(posedge clk_i)
    begin
        if (reset_i || loop_rst)
            double_clock_out_o <= 1'b0;
        else
            double_clock_out_o <= run && ((ph_r < quarter) || (lock // RL5
                && ph_r >= {quarter[14:0], 1'b0}
                && ph_r < quarter + {quarter[14:0], 1'b0}));
    end

    // half period of the divided clock is ratio times half a source period
    always_ff @(posedge clk_i)
    begin
        if (reset_i || loop_rst)
        begin
            div_cnt_r           <= 22'h00_0000;
            divided_clock_out_o <= 1'b0;
        end
        else if (run)
        begin
            if (div_cnt_r + 22'h00_0001 >= div_half)
            begin
                div_cnt_r           <= 22'h00_0000;
                divided_clock_out_o <= ~divided_clock_out_o; // RL6
            end
            else
                div_cnt_r <= div_cnt_r + 22'h00_0001;
        end
    end

    // ****************************************
    // startup hold
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            startup_release_o <= 1'b0;
        else
            startup_release_o <= config_done_i
                && (!ctrl_r[dlcm_pkg::CTRL_WAIT] || lock); // RL8 RL18
    end

    // ****************************************
    // avalon slave and registers
    // ****************************************
    // one wait cycle per access; the answer stands in the second cycle
    assign acc = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            avs_waitrequest_o <= 1'b1;
        else
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            ctrl_r <= dlcm_pkg::CTRL_RESET; // RL8
        else if (acc && avs_write_i && avs_byteenable_i[0]
                 && avs_address_i == dlcm_pkg::OFS_CTRL)
            ctrl_r <= avs_writedata_i[7:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            irq_en_r <= 4'h0;
        else if (acc && avs_write_i && avs_byteenable_i[0]
                 && avs_address_i == dlcm_pkg::OFS_IRQ_EN)
            irq_en_r <= avs_writedata_i[3:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            avs_readdata_o <= 32'h0000_0000;
        else if (avs_read_i && avs_waitrequest_o)
        begin
            case (avs_address_i)
                dlcm_pkg::OFS_CTRL:   avs_readdata_o <= {24'h00_0000, ctrl_r};
                dlcm_pkg::OFS_STATUS: avs_readdata_o <= 32'({tap_r, 4'h0, state_r, lock});
                dlcm_pkg::OFS_IRQ_ST: avs_readdata_o <= {28'h000_0000, irq_st_r};
                dlcm_pkg::OFS_IRQ_EN: avs_readdata_o <= {28'h000_0000, irq_en_r};
                dlcm_pkg::OFS_PERIOD: avs_readdata_o <= {16'h0000, per};
                default:              avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // interrupts
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            stall_q_r <= 1'b0;
            long_q_r  <= 1'b0;
        end
        else
        begin
            stall_q_r <= src_e.stall;
            long_q_r  <= src_e.overlong;
        end
    end

    assign irq_ev[dlcm_pkg::IRQ_LOCK] = aligned_fb && state_r == dlcm_pkg::ST_SEEK
                                        && 32'(align_r) == dlcm_pkg::LOCK_COUNT - 1;
    assign irq_ev[dlcm_pkg::IRQ_LOSS] = lock && loop_rst;
    assign irq_ev[dlcm_pkg::IRQ_STOP] = src_e.stall && !stall_q_r;
    assign irq_ev[dlcm_pkg::IRQ_LONG] = src_e.overlong && !long_q_r;

    // a new event beats a clear landing in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            irq_st_r <= 4'h0;
        else if (acc && avs_write_i && avs_byteenable_i[0]
                 && avs_address_i == dlcm_pkg::OFS_IRQ_CL)
            irq_st_r <= (irq_st_r & ~avs_writedata_i[3:0]) | irq_ev;
        else
            irq_st_r <= irq_st_r | irq_ev;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            irq_o <= 1'b0;
        else
            irq_o <= |((irq_st_r | irq_ev) & irq_en_r);
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    lock_drop_a: assert property (loop_reset_i |=> !locked_o) // RL1
        else $error("lock not dropped after loop reset");
    tap_clear_a: assert property (loop_rst |=> tap_r == '0) // RL3
        else $error("taps not cleared by loop reset");
    lock_cause_a: assert property ($rose(locked_o) |-> // RL19
        $past(aligned_fb) && 32'($past(align_r)) == dlcm_pkg::LOCK_COUNT - 1)
        else $error("lock without aligned feedback");
    tap_hold_a: assert property (lock && !loop_rst |=> $stable(tap_r)) // RL14
        else $error("taps moved while locked");
    stop_lock_a: assert property (lock && src_e.stall && !loop_rst |=> locked_o) // RL11
        else $error("lock lost during clock stop");
    prelock_dbl_a: assert property (!lock && !loop_rst && ph_r >= quarter // RL5
        |=> !double_clock_out_o)
        else $error("double clock high past quarter before lock");
    lock_dbl_a: assert property (lock && !loop_rst && run // RL5
        && ph_r >= {quarter[14:0], 1'b0} && ph_r < quarter + {quarter[14:0], 1'b0}
        |=> double_clock_out_o)
        else $error("second double pulse missing after lock");
    duty_fix_a: assert property (ctrl_r[dlcm_pkg::CTRL_DCC] && !loop_rst && run // RL17
        |=> aligned_clock_out_o == $past(ph_r < {1'b0, per[15:1]}))
        else $error("aligned clock duty wrong");
    div_flip_a: assert property (run && !loop_rst // RL6
        && div_cnt_r + 22'h00_0001 >= div_half |=> $changed(divided_clock_out_o))
        else $error("divided clock missed a toggle");
    flush_end_a: assert property (!run && !loop_rst && !drise // RL13
        |=> !double_clock_out_o ##1 !double_clock_out_o)
        else $error("double clock ran after flush");
    hold_start_a: assert property (ctrl_r[dlcm_pkg::CTRL_WAIT] && !lock // RL8
        |=> !startup_release_o)
        else $error("startup released before lock");

    lock_seen_c: cover property ($rose(locked_o));
    stop_seen_c: cover property (lock && src_e.stall);
    div_seen_c:  cover property (lock && $rose(divided_clock_out_o));
    irq_seen_c:  cover property ($rose(irq_o));
endmodule
`default_nettype wire

/* File: verification/dlcm_osc_model.sv */
// source oscillator and feedback path standing in front of the clock manager
`timescale 1ns/1ps
`default_nettype none
module dlcm_osc_model #(
    parameter int unsigned HALF = 8
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // oscillator control
    input  wire logic run_i,
    input  wire logic aligned_i,
    // clock pins
    output logic      src_o,
    output logic      fb_o
);
    // ****************************************
    // oscillator
    // ****************************************
    int unsigned cnt_r;

    // feedback straight from the aligned output, no other source
    assign fb_o = aligned_i;

    // fixed period, no drift or jitter; halts only while low
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            cnt_r <= 0;
            src_o <= 1'b0;
        end
        else if (src_o || run_i)
        begin
            if (cnt_r == HALF - 1)
            begin
                cnt_r <= 0;
                src_o <= !src_o;
            end
            else
                cnt_r <= cnt_r + 1;
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// self-checking testbench of the delay-locked clock manager
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ****************************************
    // signals and models
    // ****************************************
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        src, fb, al, db, dv, lk, rel, irq, wt, al_d;
    logic        lrst = 1'b0;
    logic        cdone = 1'b0;
    logic        run = 1'b1;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdat;
    logic [2:0]  clks;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int          err_count = 0;
    int          check_count = 0;
    int          r2[8] = '{3, 4, 5, 6, 8, 10, 16, 32};

    always #4 clk_i = ~clk_i;
    assign clks = {dv, db, al};
    always @(posedge clk_i) al_d <= al;

    dlcm_osc_model u_osc (.clk_i(clk_i), .reset_i(reset_i), .run_i(run),
        .aligned_i(al), .src_o(src), .fb_o(fb));
    dlcm_top #(.STOP_CYCLES(128)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
        .source_clock_in_i(src), .feedback_clock_in_i(fb), .loop_reset_i(lrst),
        .config_done_i(cdone), .aligned_clock_out_o(al), .double_clock_out_o(db),
        .divided_clock_out_o(dv), .locked_o(lk), .startup_release_o(rel), .irq_o(irq),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(4'h1), .avs_readdata_o(rdat), .avs_waitrequest_o(wt));

    // ****************************************
    // checks and bus tasks
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input int e, input int g);
        check_count++;
        if (g != e)
        begin
            err_count++;
            $display("[ERR] %s exp %0d got %0d", nm, e, g);
        end
    endtask

    task automatic chk_b(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask

    // read data taken only at the edge that sees waitrequest low
    always @(posedge clk_i)
    begin
        if (rd && wt === 1'b0)
        begin
            check_count++;
            if ((rdat & msk_q[0]) !== (exp_q[0] & msk_q[0]))
            begin
                err_count++;
                $display("[ERR] reg %h exp %h got %h", adr, exp_q[0] & msk_q[0], rdat & msk_q[0]);
            end
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        wd <= d;
        wr <= 1'b1;
        do @(posedge clk_i); while (wt !== 1'b0);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk_i);
        adr <= a;
        rd <= 1'b1;
        do @(posedge clk_i); while (wt !== 1'b0);
        rd <= 1'b0;
    endtask

    task automatic wait_lock();
        int n;
        n = 0;
        while (lk !== 1'b1 && n++ < 5000) @(posedge clk_i);
        chk_b("locked", 1'b1, lk);
    endtask

    // high and low time of one generated clock, in system cycles
    task automatic meas_chk(input int k, input string nm, input int eh, input int el);
        int n, hi, lo;
        n = 0;
        hi = 0;
        lo = 0;
        while (clks[k] !== 1'b0 && n++ < 300) @(posedge clk_i);
        while (clks[k] !== 1'b1 && n++ < 600) @(posedge clk_i);
        while (clks[k] === 1'b1 && hi++ < 300) @(posedge clk_i);
        while (clks[k] === 1'b0 && lo++ < 300) @(posedge clk_i);
        chk({nm, " high"}, eh, hi);
        chk({nm, " low"}, el, lo);
    endtask

    initial
    begin
        repeat (40000) @(posedge clk_i);
        err_count++;
        $display("[ERR] watchdog exp done got hang");
        print_verdict();
    end

    initial
    begin
        int k, n, ris;
        logic ok;
        void'($urandom(13));
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        bus_rd(8'h00, 32'h0000_0011, 32'h0000_0077);
        bus_rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
        bus_wr(8'h40, 32'h0000_00FF);
        bus_rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
        bus_wr(8'h10, 32'h0000_0001);
        bus_wr(8'h00, 32'h0000_0013);
        cdone <= 1'b1;
        repeat (3) @(posedge clk_i);
        if (lk === 1'b0)
            chk_b("release", 1'b0, rel);
        $display("test registers done");
        wait_lock();
        repeat (3) @(posedge clk_i);
        chk_b("release", 1'b1, rel);
        chk_b("irq", 1'b1, irq);
        bus_rd(8'h04, 32'h0000_0009, 32'h0000_000F);
        bus_rd(8'h14, 32'h0000_0010, 32'h0000_FFFF);
        bus_wr(8'h0C, 32'h0000_0001);
        repeat (3) @(posedge clk_i);
        chk_b("irq", 1'b0, irq);
        $display("test lock done");
        // outputs used only once lock is seen
        meas_chk(0, "aligned", 8, 8);
        meas_chk(1, "double", 4, 4);
        bus_wr(8'h00, 32'h0000_0012);
        repeat (16) @(posedge clk_i);
        meas_chk(0, "raw", 8, 8);
        k = $urandom % 8;
        for (int i = 0; i < 8; i++)
        begin
            k = (k + 1) % 8;
            bus_wr(8'h00, 32'h0000_0003 | 32'(k << 4));
            meas_chk(2, "settle", 4 * r2[k], 4 * r2[k]);
            meas_chk(2, "divided", 4 * r2[k], 4 * r2[k]);
        end
        $display("test clocks done");
        n = 70 + $urandom % 20;
        run <= 1'b0;
        ok = 1'b1;
        ris = 0;
        repeat (n)
        begin
            @(posedge clk_i);
            ok &= lk;
            ris += int'(al && !al_d);
        end
        chk("flush rises", 1, int'(ris >= 1 && ris <= 4));
        run <= 1'b1;
        n = 0;
        while (!(al && !al_d) && n++ < 200) @(posedge clk_i);
        chk("refill wait", 1, int'(n >= 1 && n <= 80));
        chk_b("lock kept", 1'b1, ok & lk);
        bus_rd(8'h08, 32'h0000_0004, 32'h0000_000C);
        run <= 1'b0;
        repeat (150) @(posedge clk_i);
        run <= 1'b1;
        chk_b("lock kept", 1'b1, lk);
        bus_rd(8'h08, 32'h0000_0008, 32'h0000_0008);
        bus_wr(8'h00, 32'h0000_0017);
        bus_rd(8'h04, 32'h0000_0000, 32'h0000_3F01);
        bus_wr(8'h00, 32'h0000_0013);
        wait_lock();
        $display("test stop done");
        bus_wr(8'h10, 32'h0000_0000);
        @(posedge clk_i);
        lrst <= 1'b1;
        n = 0;
        while (lk !== 1'b0 && n++ < 80) @(posedge clk_i);
        chk("lock loss", 1, int'(n <= 64));
        repeat (4) @(posedge clk_i);
        lrst <= 1'b0;
        chk_b("release", 1'b0, rel);
        chk_b("irq", 1'b0, irq);
        bus_rd(8'h08, 32'h0000_0002, 32'h0000_0002);
        // first period after a loop reset is bogus; seeking adds a cycle per period
        repeat (40) @(posedge clk_i);
        meas_chk(1, "double", 4, 13);
        bus_wr(8'h00, 32'h0000_0011);
        repeat (3) @(posedge clk_i);
        chk_b("release", 1'b1, rel);
        $display("test reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
